// >>> include/hcs_pkg.sv
// Purpose: Shared constants and types for the hall conversion sequencer
// Assumes: 25 MHz core clock, 32-bit Avalon-MM register access
// Notes:   Byte addresses; one register per aligned word
package hcs_pkg;
   localparam int unsigned CLK_MHZ  = 25;
   localparam int unsigned SPIN_NS  = 25000;
   localparam int unsigned ADC_NS   = 25000;
   localparam int unsigned SPIN_CYC = (SPIN_NS * CLK_MHZ + 999) / 1000;
   localparam int unsigned ADC_CYC  = (ADC_NS * CLK_MHZ + 999) / 1000;
   localparam int unsigned ANG_IT   = 11;

   localparam logic [7:0] REG_CTRL  = 8'h00;
   localparam logic [7:0] REG_LIM   = 8'h04;
   localparam logic [7:0] REG_LO    = 8'h08;
   localparam logic [7:0] REG_HI    = 8'h0c;
   localparam logic [7:0] REG_CMD   = 8'h10;
   localparam logic [7:0] REG_STAT  = 8'h14;
   localparam logic [7:0] REG_MASK  = 8'h18;
   localparam logic [7:0] REG_T     = 8'h1c;
   localparam logic [7:0] REG_X     = 8'h20;
   localparam logic [7:0] REG_Y     = 8'h24;
   localparam logic [7:0] REG_Z     = 8'h28;
   localparam logic [7:0] REG_ANG   = 8'h2c;
   localparam logic [7:0] REG_STATE = 8'h30;

   localparam logic [1:0] MODE_TRIG = 2'b00;
   localparam logic [1:0] MODE_CONT = 2'b10;
   localparam logic [1:0] CH_T      = 2'd0;
   localparam logic [1:0] CH_X      = 2'd1;
   localparam logic [1:0] CH_Y      = 2'd2;
   localparam logic [1:0] CH_Z      = 2'd3;
   localparam logic [1:0] TC_NDFEB  = 2'b01;
   localparam logic [1:0] TC_FERR   = 2'b10;
   localparam logic [2:0] AVG_MAX   = 3'd5;
   localparam int         STAT_DONE = 0;
   localparam int         STAT_LIM  = 1;
   localparam int         CMD_TRIG  = 0;

   localparam logic signed [15:0] TEMP_REF  = 16'sh0000;
   localparam logic signed [9:0]  K_NDFEB   = 10'sd79;
   localparam logic signed [9:0]  K_FERR    = 10'sd131;
   localparam int unsigned        COMP_SH   = 16;
   localparam logic signed [13:0] ANG_HALF  = 14'sd2880;
   localparam logic signed [13:0] ANG_FULL  = 14'sd5760;

   typedef struct packed {
      logic [1:0] angle_sel;
      logic [1:0] magnet_drift_coeff;
      logic [2:0] averaging_count;
      logic [3:0] axis_channel_select;
      logic [1:0] mode;
   } hcs_cfg_t;

   typedef struct packed {
      logic [2:0] axis_mask;
      logic       limit_hysteresis_sel;
      logic       limit_direction_sel;
   } hcs_lim_t;

   typedef enum logic [3:0] {
      ST_IDLE  = 4'b0001,
      ST_RUN   = 4'b0010,
      ST_ANGLE = 4'b0100,
      ST_DONE  = 4'b1000
   } hcs_state_t;

   localparam hcs_cfg_t    CTRL_RST = '0;
   localparam hcs_lim_t    LIM_RST  = '0;
   localparam logic [15:0] LO_RST   = 16'h0000;
   localparam logic [15:0] HI_RST   = 16'h0000;
   localparam logic [1:0]  MASK_RST = 2'h0;
endpackage

// >>> src/hcs_sequencer.sv
// Purpose: Conversion sequencer, averaging, drift correction, limit check, angle
// Assumes: Analog front end same clock; samples valid at end of ADC phase
// Notes:   Avalon-MM slave answers one cycle after the request
//
// The Avalon-MM slave port and the register offsets were chosen for this implementation.
`timescale 1ns/100ps
module hcs_sequencer
   import hcs_pkg::*;
#(
   parameter int unsigned CW      = 12,
   parameter int unsigned SPIN_CY = SPIN_CYC,
   parameter int unsigned ADC_CY  = ADC_CYC
) (
   input  wire logic        core_clk_i,
   input  wire logic        reset_i,
   input  wire logic [7:0]  avs_address_i,
   input  wire logic        avs_read_i,
   input  wire logic        avs_write_i,
   input  wire logic [31:0] avs_writedata_i,
   input  wire logic [3:0]  avs_byteenable_i,
   output logic      [31:0] avs_readdata_o,
   output logic             avs_waitrequest_o,
   input  wire logic        int_pin_i,
   output logic             int_pin_o,
   output logic             int_pin_oe_o,
   output logic             spin_act_o,
   output logic      [1:0]  spin_chan_o,
   output logic             conv_act_o,
   output logic      [1:0]  conv_chan_o,
   input  wire logic [15:0] afe_sample_i,
   output logic             irq_o
);
   function automatic logic [31:0] be_merge(input logic [31:0] o, input logic [31:0] n,
                                            input logic [3:0] be);
      be_merge = o;
      for (int b = 0; b < 4; b++) begin
         if (be[b]) begin
            be_merge[8*b +: 8] = n[8*b +: 8];
         end
      end
   endfunction

   // {length, third, second, first}
   function automatic logic [7:0] seq_tab(input logic [3:0] s);
      case (s)
         4'b0001: seq_tab = {2'd1, CH_T, CH_T, CH_X};
         4'b0010: seq_tab = {2'd1, CH_T, CH_T, CH_Y};
         4'b0011: seq_tab = {2'd2, CH_T, CH_Y, CH_X};
         4'b0100: seq_tab = {2'd1, CH_T, CH_T, CH_Z};
         4'b0101: seq_tab = {2'd2, CH_T, CH_X, CH_Z};
         4'b0110: seq_tab = {2'd2, CH_T, CH_Z, CH_Y};
         4'b0111: seq_tab = {2'd3, CH_Z, CH_Y, CH_X};
         4'b1000: seq_tab = {2'd3, CH_X, CH_Y, CH_X};
         4'b1001: seq_tab = {2'd3, CH_Y, CH_X, CH_Y};
         4'b1010: seq_tab = {2'd3, CH_Y, CH_Z, CH_Y};
         4'b1011: seq_tab = {2'd3, CH_X, CH_Z, CH_X};
         default: seq_tab = 8'h00;
      endcase
   endfunction

   function automatic logic [1:0] chan_cnt(input logic [7:0] tb, input logic [1:0] c);
      chan_cnt = 2'd0;
      for (int i = 0; i < 3; i++) begin
         if (2'(i) < tb[7:6] && tb[2*i +: 2] == c) begin
            chan_cnt = chan_cnt + 2'd1;
         end
      end
   endfunction

   function automatic logic [15:0] avg_of(input logic signed [21:0] a, input logic [2:0] sh);
      logic signed [21:0] t;
      t = a >>> sh;
      avg_of = t[15:0];
   endfunction

   // Wraps rather than saturates at full scale
   function automatic logic [15:0] comp(input logic signed [15:0] m,
                                        input logic signed [15:0] t, input logic [1:0] c);
      logic signed [16:0] dt;
      logic signed [9:0]  k;
      logic signed [42:0] p;
      dt = 17'(t) - 17'(TEMP_REF);
      k = (c == TC_NDFEB) ? K_NDFEB : (c == TC_FERR) ? K_FERR : 10'sd0;
      p = m * dt * k;
      comp = m + p[15+COMP_SH:COMP_SH];
   endfunction

   function automatic logic lim_chk(input logic signed [15:0] v, input logic signed [15:0] lo,
                                    input logic signed [15:0] hi, input logic d, input logic h);
      logic inb;
      inb = (v >= lo) && (v <= hi);
      lim_chk = h ? (d ? inb : !inb) : (d ? (v < lo) : (v > hi));
   endfunction

   function automatic logic signed [13:0] atan_t(input logic [3:0] i);
      case (i)
         4'd0:    atan_t = 14'sd720;
         4'd1:    atan_t = 14'sd425;
         4'd2:    atan_t = 14'sd225;
         4'd3:    atan_t = 14'sd114;
         4'd4:    atan_t = 14'sd57;
         4'd5:    atan_t = 14'sd29;
         4'd6:    atan_t = 14'sd14;
         4'd7:    atan_t = 14'sd7;
         4'd8:    atan_t = 14'sd4;
         4'd9:    atan_t = 14'sd2;
         4'd10:   atan_t = 14'sd1;
         default: atan_t = 14'sd0;
      endcase
   endfunction

   hcs_cfg_t           cfg_q;
   hcs_lim_t           lim_q;
   hcs_state_t         st_q, st_d;
   logic signed [15:0] lo_q, hi_q;
   logic        [1:0]  mask_q, stat_q, slot_q;
   logic               ack_q, iss_done_q;
   logic        [31:0] rdata_q;
   logic               pin_s1_q, pin_s2_q, pin_s3_q, flt_q;
   logic        [4:0]  rep_q;
   logic               sp_act_q, ad_act_q;
   logic        [CW-1:0] sp_cnt_q, ad_cnt_q;
   logic        [1:0]  sp_ch_q, ad_ch_q;
   logic signed [21:0] acc_q [4];
   logic        [15:0] res_q [4];
   logic        [15:0] raw [4];
   logic        [15:0] nres [4];
   logic signed [17:0] x_q, y_q;
   logic signed [13:0] z_q;
   logic        [3:0]  it_q;
   logic        [12:0] ang_q;

   // Register bus
   wire        req     = avs_read_i | avs_write_i;
   wire        wr_go   = avs_write_i & ack_q;
   wire        rd_go   = avs_read_i & ack_q;
   wire [7:0]  a       = avs_address_i;
   wire [31:0] rmux    = (a == REG_CTRL)  ? 32'(cfg_q) :
                         (a == REG_LIM)   ? 32'(lim_q) :
                         (a == REG_LO)    ? {16'h0000, lo_q} :
                         (a == REG_HI)    ? {16'h0000, hi_q} :
                         (a == REG_STAT)  ? {30'h0, stat_q} :
                         (a == REG_MASK)  ? {30'h0, mask_q} :
                         (a == REG_T)     ? {16'h0000, res_q[CH_T]} :
                         (a == REG_X)     ? {16'h0000, res_q[CH_X]} :
                         (a == REG_Y)     ? {16'h0000, res_q[CH_Y]} :
                         (a == REG_Z)     ? {16'h0000, res_q[CH_Z]} :
                         (a == REG_ANG)   ? {19'h0, ang_q} :
                         (a == REG_STATE) ? {28'h0, st_q} : 32'h0;
   wire [31:0] wm      = be_merge(rmux, avs_writedata_i, avs_byteenable_i);
   wire        cmd_trg = wr_go & (a == REG_CMD) & wm[CMD_TRIG];

   assign avs_waitrequest_o = req & ~ack_q;
   assign avs_readdata_o    = rdata_q;

   // Sequencing decode
   wire        cont     = cfg_q.mode == MODE_CONT;
   wire        trg_mode = cfg_q.mode == MODE_TRIG;
   wire        pin_trg  = flt_q & ~pin_s2_q & ~pin_s3_q & ~int_pin_oe_o;
   wire        trig     = (cmd_trg | pin_trg) & trg_mode;
   wire        go       = cont | trig;
   wire        restart  = (st_q == ST_IDLE & go) | (st_q == ST_DONE & cont);
   wire [7:0]  tab      = seq_tab(cfg_q.axis_channel_select);
   wire [1:0]  nax      = tab[7:6];
   wire [2:0]  avg      = (cfg_q.averaging_count > AVG_MAX) ? AVG_MAX
                                                            : cfg_q.averaging_count;
   wire [5:0]  nrep     = 6'd1 << avg;
   wire [4:0]  rep_last = 5'(nrep - 6'd1);
   wire [1:0]  slot_m1  = slot_q - 2'd1;
   wire [1:0]  iss_ch   = (slot_q == 2'd0) ? CH_T : tab[2*slot_m1 +: 2];
   wire        last_iss = (rep_q == rep_last) & (slot_q == nax);
   wire        sp_end   = sp_act_q & (sp_cnt_q == CW'(SPIN_CY - 1));
   wire        ad_end   = ad_act_q & (ad_cnt_q == CW'(ADC_CY - 1));
   wire        hand     = sp_end & (~ad_act_q | ad_end);
   wire        go_spin  = (st_q == ST_RUN) & ~iss_done_q & (~sp_act_q | hand);
   wire        pass_end = (st_q == ST_RUN) & iss_done_q & ~sp_act_q & ~ad_act_q;
   wire        ang_on   = cfg_q.angle_sel != 2'b00;
   wire        it_last  = it_q == 4'(ANG_IT - 1);
   wire signed [15:0] ca = (cfg_q.angle_sel == 2'b10) ? nres[CH_Y] : nres[CH_X];
   wire signed [15:0] cb = (cfg_q.angle_sel == 2'b01) ? nres[CH_Y] : nres[CH_Z];
   wire signed [17:0] xs = x_q >>> it_q;
   wire signed [17:0] ys = y_q >>> it_q;
   wire        yneg     = y_q[17];
   wire [2:0]  lhit     = {lim_chk(res_q[CH_Z], lo_q, hi_q, lim_q.limit_direction_sel,
                                   lim_q.limit_hysteresis_sel),
                           lim_chk(res_q[CH_Y], lo_q, hi_q, lim_q.limit_direction_sel,
                                   lim_q.limit_hysteresis_sel),
                           lim_chk(res_q[CH_X], lo_q, hi_q, lim_q.limit_direction_sel,
                                   lim_q.limit_hysteresis_sel)};
   wire        lim_hit  = |(lhit & lim_q.axis_mask);
   wire [1:0]  st_set   = {(st_q == ST_DONE) & lim_hit, st_q == ST_DONE};
   // Clear only the bits the read returned; a set during the read survives
   wire [1:0]  st_clr   = (rd_go & (a == REG_STAT)) ? rdata_q[1:0] : 2'b00;

   assign irq_o        = |(stat_q & mask_q);
   assign int_pin_o    = 1'b0;
   assign int_pin_oe_o = irq_o;
   assign spin_act_o   = sp_act_q;
   assign spin_chan_o  = sp_ch_q;
   assign conv_act_o   = ad_act_q;
   assign conv_chan_o  = ad_ch_q;

   always_comb begin
      for (int c = 0; c < 4; c++) begin
         raw[c]  = avg_of(acc_q[c], avg + 3'(chan_cnt(tab, 2'(c)) == 2'd2));
         nres[c] = (c == 0) ? raw[c] : comp(raw[c], raw[CH_T], cfg_q.magnet_drift_coeff);
      end
   end

   always_comb begin
      st_d = st_q;
      unique case (st_q)
         ST_IDLE:  if (go) st_d = ST_RUN;
         ST_RUN:   if (pass_end) st_d = ang_on ? ST_ANGLE : ST_DONE;
         ST_ANGLE: if (it_last) st_d = ST_DONE;
         ST_DONE:  st_d = cont ? ST_RUN : ST_IDLE;
      endcase
   end

   always_ff @(posedge core_clk_i) begin
      if (reset_i) begin
         cfg_q  <= CTRL_RST;
         lim_q  <= LIM_RST;
         lo_q   <= LO_RST;
         hi_q   <= HI_RST;
         mask_q <= MASK_RST;
      end else if (wr_go) begin
         if (a == REG_CTRL) cfg_q <= hcs_cfg_t'(wm[$bits(hcs_cfg_t)-1:0]);
         if (a == REG_LIM) lim_q <= hcs_lim_t'(wm[$bits(hcs_lim_t)-1:0]);
         if (a == REG_LO) lo_q <= wm[15:0];
         if (a == REG_HI) hi_q <= wm[15:0];
         if (a == REG_MASK) mask_q <= wm[1:0];
      end
   end

   // Set wins over the read clear
   always_ff @(posedge core_clk_i) begin
      if (reset_i) begin
         ack_q   <= 1'b0;
         rdata_q <= 32'h0;
         stat_q  <= 2'h0;
      end else begin
         ack_q  <= req & ~ack_q;
         stat_q <= (stat_q & ~st_clr) | st_set;
         if (avs_read_i & ~ack_q) rdata_q <= rmux;
      end
   end

   // Pin idles high; own drive masks self-triggering
   always_ff @(posedge core_clk_i) begin
      if (reset_i) begin
         pin_s1_q <= 1'b1;
         pin_s2_q <= 1'b1;
         pin_s3_q <= 1'b1;
         flt_q    <= 1'b1;
      end else begin
         pin_s1_q <= int_pin_i;
         pin_s2_q <= pin_s1_q;
         pin_s3_q <= pin_s2_q;
         if (pin_s2_q == pin_s3_q) flt_q <= pin_s3_q;
      end
   end

   always_ff @(posedge core_clk_i) begin
      if (reset_i) begin
         st_q <= ST_IDLE;
      end else begin
         st_q <= st_d;
      end
   end

   // Spin stage holds its sample until the ADC can take it
   always_ff @(posedge core_clk_i) begin
      if (reset_i) begin
         sp_act_q <= 1'b0;
         sp_cnt_q <= '0;
         sp_ch_q  <= CH_T;
      end else if (go_spin) begin
         sp_act_q <= 1'b1;
         sp_cnt_q <= '0;
         sp_ch_q  <= iss_ch;
      end else if (hand) begin
         sp_act_q <= 1'b0;
      end else if (sp_act_q & ~sp_end) begin
         sp_cnt_q <= sp_cnt_q + 1'b1;
      end
   end

   always_ff @(posedge core_clk_i) begin
      if (reset_i) begin
         ad_act_q <= 1'b0;
         ad_cnt_q <= '0;
         ad_ch_q  <= CH_T;
      end else if (hand) begin
         ad_act_q <= 1'b1;
         ad_cnt_q <= '0;
         ad_ch_q  <= sp_ch_q;
      end else if (ad_end) begin
         ad_act_q <= 1'b0;
      end else if (ad_act_q) begin
         ad_cnt_q <= ad_cnt_q + 1'b1;
      end
   end

   always_ff @(posedge core_clk_i) begin
      if (reset_i | restart) begin
         slot_q     <= 2'd0;
         rep_q      <= 5'd0;
         iss_done_q <= 1'b0;
      end else if (go_spin) begin
         if (last_iss) begin
            iss_done_q <= 1'b1;
         end else if (rep_q == rep_last) begin
            rep_q  <= 5'd0;
            slot_q <= slot_q + 2'd1;
         end else begin
            rep_q <= rep_q + 5'd1;
         end
      end
   end

   always_ff @(posedge core_clk_i) begin
      for (int c = 0; c < 4; c++) begin
         if (reset_i) begin
            acc_q[c] <= 22'sd0;
            res_q[c] <= 16'h0000;
         end else begin
            if (restart) begin
               acc_q[c] <= 22'sd0;
            end else if (ad_end && ad_ch_q == 2'(c)) begin
               acc_q[c] <= acc_q[c] + 22'(signed'(afe_sample_i));
            end
            if (pass_end && (c == 0 || chan_cnt(tab, 2'(c)) != 2'd0)) begin
               res_q[c] <= nres[c];
            end
         end
      end
   end

   // Vectoring angle, sixteenths of a degree
   always_ff @(posedge core_clk_i) begin
      if (reset_i) begin
         x_q   <= 18'sd0;
         y_q   <= 18'sd0;
         z_q   <= 14'sd0;
         it_q  <= 4'd0;
         ang_q <= 13'h0000;
      end else if (pass_end) begin
         x_q  <= ca[15] ? -18'(ca) : 18'(ca);
         y_q  <= ca[15] ? -18'(cb) : 18'(cb);
         z_q  <= ca[15] ? ANG_HALF : 14'sd0;
         it_q <= 4'd0;
      end else if (st_q == ST_ANGLE) begin
         x_q  <= yneg ? x_q - ys : x_q + ys;
         y_q  <= yneg ? y_q + xs : y_q - xs;
         z_q  <= yneg ? z_q - atan_t(it_q) : z_q + atan_t(it_q);
         it_q <= it_q + 4'd1;
      end else if (st_q == ST_DONE && ang_on) begin
         ang_q <= z_q[13] ? 13'(z_q + ANG_FULL) : 13'(z_q);
      end
   end

   property p_cont;
      @(posedge core_clk_i) disable iff (reset_i) (st_q == ST_DONE && cont) |=> st_q == ST_RUN;
   endproperty
   a_cont: assert property (p_cont) else $error("continuous pass not restarted");

   property p_pipe;
      @(posedge core_clk_i) disable iff (reset_i)
         (hand && !iss_done_q) |=> (ad_act_q && ad_cnt_q == '0 && sp_act_q && sp_cnt_q == '0);
   endproperty
   a_pipe: assert property (p_pipe) else $error("spin did not overlap conversion");

   property p_tfirst;
      @(posedge core_clk_i) disable iff (reset_i)
         (restart && cont) |-> ##2 (sp_act_q && sp_ch_q == CH_T);
   endproperty
   a_tfirst: assert property (p_tfirst) else $error("pass did not begin with temp");

   property p_trig;
      @(posedge core_clk_i) disable iff (reset_i)
         (st_q == ST_IDLE && trg_mode && (cmd_trg || pin_trg)) |=> st_q == ST_RUN;
   endproperty
   a_trig: assert property (p_trig) else $error("trigger did not start a pass");

   property p_xzx;
      @(posedge core_clk_i) disable iff (reset_i)
         (go_spin && cfg_q.axis_channel_select == 4'b1011 && slot_q == 2'd2)
         |=> sp_ch_q == CH_Z;
   endproperty
   a_xzx: assert property (p_xzx) else $error("middle sample not Z");

   property p_lim;
      @(posedge core_clk_i) disable iff (reset_i)
         (st_q == ST_DONE && lim_hit) |=> stat_q[STAT_LIM];
   endproperty
   a_lim: assert property (p_lim) else $error("limit hit not flagged");

   property p_notc;
      @(posedge core_clk_i) disable iff (reset_i)
         (cfg_q.magnet_drift_coeff == 2'b00) |-> nres[CH_X] == raw[CH_X];
   endproperty
   a_notc: assert property (p_notc) else $error("compensation applied at 00b");

   property p_idle;
      @(posedge core_clk_i) disable iff (reset_i)
         (st_q == ST_DONE && trg_mode) |=> (st_q == ST_IDLE && !sp_act_q && !ad_act_q);
   endproperty
   a_idle: assert property (p_idle) else $error("converter busy after one pass");

   property p_ack;
      @(posedge core_clk_i) disable iff (reset_i)
         $rose(req) |-> avs_waitrequest_o ##1 !avs_waitrequest_o;
   endproperty
   a_ack: assert property (p_ack) else $error("bus answer not after one cycle");
endmodule

// >>> tb/hcs_afe_model.sv
// Purpose: Front-end stand-in giving one fixed sample per channel
// Assumes: Sample taken on last ADC cycle
// Notes:   Line toggles outside conversions
`timescale 1ns/100ps
module hcs_afe_model
   import hcs_pkg::*;
(
   input  wire logic        core_clk_i,
   input  wire logic        conv_act_i,
   input  wire logic [1:0]  conv_chan_i,
   output logic      [15:0] afe_sample_o = 16'h5a5a
);
   logic [15:0] val;
   assign val = (conv_chan_i == CH_T) ? 16'h0040 :
                (conv_chan_i == CH_Z) ? 16'h0189 : 16'h0123;
   // Toggling exposes a sample taken outside its slot
   always @(posedge core_clk_i) begin
      afe_sample_o <= conv_act_i ? val : ~afe_sample_o;
   end
endmodule

// >>> tb/hcs_sequencer_tb_top.sv
// Purpose: Self-checking bench for the conversion sequencer
// Assumes: Short spin and ADC phases of 4 cycles
// Notes:   X and Y read 0x123, Z 0x189, T 0x40
`timescale 1ns/100ps
module hcs_sequencer_tb_top
   import hcs_pkg::*;
();
   typedef struct packed {
      logic [31:0] ctrl;
      logic [4:0]  lim;
      logic [15:0] lo, hi;
      logic [5:0]  nx, ny, nz;
      logic [1:0]  stat;
   } hcs_row_t;
   logic        core_clk_i = 1'b0;
   logic        reset_i    = 1'b1;
   logic        rd = 1'b0, wr = 1'b0, host_pull = 1'b0;
   logic [7:0]  addr = 8'h00;
   logic [31:0] wd = 32'h0, rdat, q;
   logic [15:0] afe;
   logic [1:0]  spin_chan, conv_chan;
   logic        waitreq, pin_o, pin_oe, spin_act, conv_act, irq;
   wire         pin = (pin_oe | host_pull) ? 1'b0 : 1'b1;
   int          errors = 0, tests_run = 0, ovl = 0, cc = 0, cyc = 0;
   logic [1:0]  seq[$];
   int          st[$];
   hcs_row_t    r;
   hcs_row_t    rows [12] = '{
      '{32'h2c, 5'h00, 16'h0, 16'h0, 6'd2, 6'd0, 6'd1, 2'd1},
      '{32'h28, 5'h00, 16'h0, 16'h0, 6'd0, 6'd2, 6'd1, 2'd1},
      '{32'h44, 5'h00, 16'h0, 16'h0, 6'd2, 6'd0, 6'd0, 2'd1},
      '{32'h144, 5'h00, 16'h0, 16'h0, 6'd32, 6'd0, 6'd0, 2'd1},
      '{32'h1c4, 5'h00, 16'h0, 16'h0, 6'd32, 6'd0, 6'd0, 2'd1},
      '{32'h1c, 5'h00, 16'h0, 16'h0, 6'd1, 6'd1, 6'd1, 2'd1},
      '{32'h04, 5'h10, 16'h0, 16'h100, 6'd1, 6'd0, 6'd0, 2'd3},
      '{32'h04, 5'h11, 16'h100, 16'h200, 6'd1, 6'd0, 6'd0, 2'd1},
      '{32'h04, 5'h12, 16'h100, 16'h200, 6'd1, 6'd0, 6'd0, 2'd1},
      '{32'h04, 5'h13, 16'h100, 16'h200, 6'd1, 6'd0, 6'd0, 2'd3},
      '{32'h1c, 5'h04, 16'h0, 16'h150, 6'd1, 6'd1, 6'd1, 2'd1},
      '{32'h1c, 5'h18, 16'h0, 16'h150, 6'd1, 6'd1, 6'd1, 2'd3}};
   hcs_sequencer #(.SPIN_CY(4), .ADC_CY(4)) i_dut (
      .core_clk_i(core_clk_i), .reset_i(reset_i), .avs_address_i(addr),
      .avs_read_i(rd), .avs_write_i(wr), .avs_writedata_i(wd),
      .avs_byteenable_i(4'hf), .avs_readdata_o(rdat), .avs_waitrequest_o(waitreq),
      .int_pin_i(pin), .int_pin_o(pin_o), .int_pin_oe_o(pin_oe),
      .spin_act_o(spin_act), .spin_chan_o(spin_chan), .conv_act_o(conv_act),
      .conv_chan_o(conv_chan), .afe_sample_i(afe), .irq_o(irq));
   hcs_afe_model i_afe (.core_clk_i(core_clk_i), .conv_act_i(conv_act),
      .conv_chan_i(conv_chan), .afe_sample_o(afe));
   initial forever #20 core_clk_i = ~core_clk_i;
   // Slot starts: every 4th busy ADC cycle
   always @(posedge core_clk_i) begin
      cyc <= cyc + 1;
      if (spin_act && conv_act) ovl <= ovl + 1;
      if (conv_act) begin
         cc <= cc + 1;
         if (cc % 4 == 0) begin
            seq.push_back(conv_chan);
            st.push_back(cyc);
         end
      end
   end
   task final_report;
      $display("comparisons %0d mismatches %0d", tests_run, errors);
      if (errors == 0 && tests_run > 0) $display("== PASSED ==");
      else $display("== FAILED ==");
      $finish;
   endtask
   task check(input logic [31:0] seen, input logic [31:0] exp);
      tests_run++;
      if (seen !== exp) begin
         errors++;
         $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask
   task bus(input logic w, input logic [7:0] a, input logic [31:0] d);
      int n;
      @(posedge core_clk_i);
      addr <= a;
      wd <= d;
      rd <= ~w;
      wr <= w;
      n = 0;
      do begin
         @(posedge core_clk_i);
         n++;
      end while (waitreq !== 1'b0 && n < 50);
      q = rdat;
      if (n >= 50) errors++;
      rd <= 1'b0;
      wr <= 1'b0;
   endtask
   // Bounded wait; an edge first so a just-cleared level has landed
   task wait_irq;
      int n;
      n = 0;
      do begin
         @(posedge core_clk_i);
         n++;
      end while (irq !== 1'b1 && n < 2000);
      if (n >= 2000) errors++;
   endtask
   function int cnt(input logic [1:0] c);
      cnt = 0;
      foreach (seq[k]) if (seq[k] === c) cnt++;
   endfunction
   initial begin
      repeat (10) @(posedge core_clk_i);
      reset_i <= 1'b0;
      bus(0, REG_STATE, 32'h0);
      check(q, 32'h1);
      check({irq, pin_oe, spin_act, conv_act}, 32'h0);
      bus(1, 8'h3c, 32'h55);
      bus(0, 8'h3c, 32'h0);
      check(q, 32'h0);
      bus(1, REG_MASK, 32'h1);
      $display("reset and map test done");
      for (int i = 0; i < 12; i++) begin
         r = rows[i];
         bus(1, REG_CTRL, r.ctrl);
         bus(1, REG_LIM, 32'(r.lim));
         bus(1, REG_LO, 32'(r.lo));
         bus(1, REG_HI, 32'(r.hi));
         seq.delete();
         st.delete();
         bus(1, REG_CMD, 32'h1);
         wait_irq();
         bus(0, REG_STAT, 32'h0);
         check(q, 32'(r.stat));
         check(32'(cnt(CH_X)), 32'(r.nx));
         check(32'(cnt(CH_Y)), 32'(r.ny));
         check(32'(cnt(CH_Z)), 32'(r.nz));
         if (r.nx > 0) begin
            bus(0, REG_X, 32'h0);
            check(q, 32'h123);
         end
         if (r.nz == 1 && (r.nx == 2 || r.ny == 2)) begin
            check(32'(seq[2]), 32'(CH_Z));
            check(st[2] - st[1], st[3] - st[2]);
         end
         $display("row %0d test done", i);
      end
      check(32'(ovl > 0), 32'h1);
      seq.delete();
      host_pull <= 1'b1;
      repeat (4) @(posedge core_clk_i);
      host_pull <= 1'b0;
      wait_irq();
      bus(0, REG_STAT, 32'h0);
      check(q[0], 1'b1);
      seq.delete();
      bus(1, REG_CMD, 32'h1);
      bus(1, REG_CMD, 32'h1);
      wait_irq();
      check({pin_o, pin_oe}, 32'h1);
      repeat (200) @(posedge core_clk_i);
      check(32'(cnt(CH_T)), 32'h1);
      check({spin_act, conv_act}, 32'h0);
      bus(0, REG_STAT, 32'h0);
      bus(1, REG_MASK, 32'h0);
      bus(1, REG_CMD, 32'h1);
      repeat (200) @(posedge core_clk_i);
      check(irq, 1'b0);
      bus(0, REG_STAT, 32'h0);
      check(q, 32'h3);
      bus(1, REG_MASK, 32'h3);
      bus(1, REG_CTRL, 32'h204);
      bus(1, REG_CMD, 32'h1);
      wait_irq();
      bus(0, REG_X, 32'h0);
      check(q, 32'h123 + ((32'h123 * 32'h40 * 32'(K_NDFEB)) >> COMP_SH));
      bus(0, REG_STAT, 32'h0);
      $display("trigger and mask test done");
      bus(1, REG_CTRL, 32'h80c);
      bus(1, REG_CMD, 32'h1);
      wait_irq();
      bus(0, REG_ANG, 32'h0);
      check(32'(q >= 716 && q <= 724), 32'h1);
      bus(0, REG_Y, 32'h0);
      check(q, 32'h123);
      bus(0, REG_STAT, 32'h0);
      bus(1, REG_LIM, 32'h10);
      bus(1, REG_HI, 32'h100);
      bus(1, REG_CTRL, 32'h06);
      wait_irq();
      bus(0, REG_STAT, 32'h0);
      check(q, 32'h3);
      seq.delete();
      wait_irq();
      bus(0, REG_STAT, 32'h0);
      check(q, 32'h3);
      check(32'(cnt(CH_T) > 0), 32'h1);
      bus(0, REG_T, 32'h0);
      check(q, 32'h40);
      bus(1, REG_CTRL, 32'h0);
      $display("angle and continuous test done");
      final_report();
   end
   initial begin
      repeat (40000) @(posedge core_clk_i);
      errors++;
      final_report();
   end
endmodule
